// *** core/pwm_mux_pkg.sv ***
package pwm_mux_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int CH_N = 8;
   localparam int DATA_W = 32;
   localparam int ADR_W = 10;
   localparam int IDX_W = 8;
   localparam int IDX_LSB = 2;

   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_MODE = 8'hbb;
   localparam logic [IDX_W-1:0] IDX_DATA = 8'hbc;
   localparam logic [IDX_W-1:0] IDX_PSEL = 8'hbd;
   localparam logic [IDX_W-1:0] IDX_CHEN = 8'hbe;
   localparam logic [IDX_W-1:0] IDX_OPT = 8'hc8;
   localparam logic [IDX_W-1:0] IDX_PIN = 8'hc9;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int OPT_EVEN_BIT = 0;
   localparam int OPT_ODD_BIT = 1;
   localparam int OPT_W = 2;
   localparam int SEL_LANE0 = 0;
   localparam logic [CH_N-1:0] MODE_RST = 8'h00;
   localparam logic [CH_N-1:0] DATA_RST = 8'h00;
   localparam logic [CH_N-1:0] PSEL_RST = 8'h00;
   localparam logic [CH_N-1:0] CHEN_RST = 8'h00;
   localparam logic [OPT_W-1:0] OPT_RST = 2'h0;
   localparam logic [CH_N-1:0] PIN_RST = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Bus handshake states
   // ----------------------------------------------------------------
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_type;

endpackage : pwm_mux_pkg

// *** core/override_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface override_if #(
   parameter int CH_N = pwm_mux_pkg::CH_N
);
   logic [CH_N-1:0] mode;
   logic [CH_N-1:0] data;
   logic [CH_N-1:0] gen;
   logic [CH_N-1:0] chan_out;

   modport ctrl (output mode, output data, output gen, input chan_out);
   modport stage (input mode, input data, input gen, output chan_out);
endinterface : override_if

`default_nettype wire

// *** core/override_stage.sv ***
`timescale 1ns/1ps
`default_nettype none

module override_stage #(
   parameter int CH_N = pwm_mux_pkg::CH_N
) (
   override_if.stage ovr
);

   // ----------------------------------------------------------------
   // Per-channel override multiplexer
   // ----------------------------------------------------------------
   genvar n;
   generate
      for (n = 0; n < CH_N; n++) begin : g_ch
         // Override bit n drives channel n, 1 is the active level
         assign ovr.chan_out[n] = ovr.mode[n] ? ovr.data[n] : ovr.gen[n]; // [R1] [R2] [R3]
      end
   endgenerate

endmodule : override_stage

`default_nettype wire

// *** core/pwm_output_override_mux.sv ***
// How it works
// R1 - Override clear: generator waveform passes unchanged
// R2 - Override set: channel takes override data bit
// R3 - Data bit n drives channel n; 1 active
// R4 - Select 1 gives port register, 0 PWM
// R5 - Select only counts when option enabled
// R6 - Reset clears all pin select bits
// R7 - Override sits ahead of pin selector
`timescale 1ns/1ps
`default_nettype none

module pwm_output_override_mux #(
   parameter int CH_N = pwm_mux_pkg::CH_N
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [pwm_mux_pkg::ADR_W-1:0] adr_i,
   input wire logic [pwm_mux_pkg::DATA_W-1:0] dat_i,
   output logic [pwm_mux_pkg::DATA_W-1:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [CH_N-1:0] pwm_gen_i,
   input wire logic [CH_N-1:0] port_reg_i,
   output logic [CH_N-1:0] pin_o,
   output logic [CH_N-1:0] pwm_route_o,
   output logic [CH_N-1:0] channel_output_enable_o
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [CH_N-1:0] override_mode_enable_q;
   logic [CH_N-1:0] override_output_data_q;
   logic [CH_N-1:0] pin_source_select_q;
   logic [CH_N-1:0] channel_output_enable_q;
   logic [pwm_mux_pkg::OPT_W-1:0] enable_option_q;
   logic [CH_N-1:0] pin_q;
   logic [CH_N-1:0] route_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   pwm_mux_pkg::bus_state_type bus_state_q;
   logic [pwm_mux_pkg::IDX_W-1:0] idx;
   logic access;
   logic wr_lane0;
   logic [pwm_mux_pkg::DATA_W-1:0] rd_d;
   logic [pwm_mux_pkg::DATA_W-1:0] dat_q;
   logic ack_q;

   assign idx = adr_i[pwm_mux_pkg::IDX_LSB +: pwm_mux_pkg::IDX_W];
   assign access = cyc_i && stb_i && (bus_state_q == pwm_mux_pkg::BUS_IDLE);
   assign wr_lane0 = access && we_i && sel_i[pwm_mux_pkg::SEL_LANE0];

   function automatic logic wr_hit(input logic [pwm_mux_pkg::IDX_W-1:0] a,
                                   input logic [pwm_mux_pkg::IDX_W-1:0] target,
                                   input logic strobe);
      wr_hit = strobe && (a == target);
   endfunction : wr_hit

   function automatic logic [pwm_mux_pkg::DATA_W-1:0] widen(input logic [CH_N-1:0] v);
      widen = {{(pwm_mux_pkg::DATA_W - CH_N){1'b0}}, v};
   endfunction : widen

   // ----------------------------------------------------------------
   // Bus handshake: ack one cycle after the request, then drop
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_q <= pwm_mux_pkg::BUS_IDLE;
         ack_q <= 1'b0;
      end else begin
         case (bus_state_q)
            pwm_mux_pkg::BUS_IDLE: begin
               if (cyc_i && stb_i) begin
                  bus_state_q <= pwm_mux_pkg::BUS_ACK;
                  ack_q <= 1'b1;
               end else begin
                  ack_q <= 1'b0;
               end
            end
            pwm_mux_pkg::BUS_ACK: begin
               bus_state_q <= pwm_mux_pkg::BUS_IDLE;
               ack_q <= 1'b0;
            end
            default: begin
               bus_state_q <= pwm_mux_pkg::BUS_IDLE;
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data, unmapped indices read as zero
   // ----------------------------------------------------------------
   always_comb begin
      case (idx)
         pwm_mux_pkg::IDX_MODE: rd_d = widen(override_mode_enable_q);
         pwm_mux_pkg::IDX_DATA: rd_d = widen(override_output_data_q);
         pwm_mux_pkg::IDX_PSEL: rd_d = widen(pin_source_select_q);
         pwm_mux_pkg::IDX_CHEN: rd_d = widen(channel_output_enable_q);
         pwm_mux_pkg::IDX_OPT: begin
            rd_d = {{(pwm_mux_pkg::DATA_W - pwm_mux_pkg::OPT_W){1'b0}}, enable_option_q};
         end
         pwm_mux_pkg::IDX_PIN: rd_d = widen(pin_q);
         default: rd_d = pwm_mux_pkg::READ_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= pwm_mux_pkg::READ_ZERO;
      end else if (access && !we_i) begin
         dat_q <= rd_d;
      end
   end

   // ----------------------------------------------------------------
   // Writable registers, one process each
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         override_mode_enable_q <= pwm_mux_pkg::MODE_RST;
      end else if (wr_hit(idx, pwm_mux_pkg::IDX_MODE, wr_lane0)) begin
         override_mode_enable_q <= dat_i[CH_N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         override_output_data_q <= pwm_mux_pkg::DATA_RST;
      end else if (wr_hit(idx, pwm_mux_pkg::IDX_DATA, wr_lane0)) begin
         override_output_data_q <= dat_i[CH_N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_source_select_q <= pwm_mux_pkg::PSEL_RST; // [R6]
      end else if (wr_hit(idx, pwm_mux_pkg::IDX_PSEL, wr_lane0)) begin
         pin_source_select_q <= dat_i[CH_N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_output_enable_q <= pwm_mux_pkg::CHEN_RST;
      end else if (wr_hit(idx, pwm_mux_pkg::IDX_CHEN, wr_lane0)) begin
         channel_output_enable_q <= dat_i[CH_N-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_option_q <= pwm_mux_pkg::OPT_RST;
      end else if (wr_hit(idx, pwm_mux_pkg::IDX_OPT, wr_lane0)) begin
         enable_option_q <= dat_i[pwm_mux_pkg::OPT_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Override stage ahead of the pin selector
   // ----------------------------------------------------------------
   override_if #(.CH_N(CH_N)) ovr ();

   assign ovr.mode = override_mode_enable_q;
   assign ovr.data = override_output_data_q;
   assign ovr.gen = pwm_gen_i;

   override_stage #(.CH_N(CH_N)) u_override (
      .ovr(ovr.stage)
   );

   // ----------------------------------------------------------------
   // Pin source selection
   // ----------------------------------------------------------------
   logic [CH_N-1:0] option_on;
   logic [CH_N-1:0] route_d;
   logic [CH_N-1:0] pin_d;

   genvar n;
   generate
      for (n = 0; n < CH_N; n++) begin : g_pin
         // Odd pins follow the odd option, even pins the even option
         if (n % 2 == 1) begin : g_odd
            assign option_on[n] = enable_option_q[pwm_mux_pkg::OPT_ODD_BIT];
         end else begin : g_even
            assign option_on[n] = enable_option_q[pwm_mux_pkg::OPT_EVEN_BIT];
         end
         // Without the option and the channel enable the pin stays a port pin
         assign route_d[n] = option_on[n] && channel_output_enable_q[n] && !pin_source_select_q[n]; // [R4] [R5]
         // PWM path carries the overridden channel value
         assign pin_d[n] = route_d[n] ? ovr.chan_out[n] : port_reg_i[n]; // [R4] [R7]
      end
   endgenerate

   // ----------------------------------------------------------------
   // Registered pin outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_q <= pwm_mux_pkg::PIN_RST;
         route_q <= pwm_mux_pkg::PIN_RST;
      end else begin
         pin_q <= pin_d;
         route_q <= route_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pin_o = pin_q;
   assign pwm_route_o = route_q;
   assign channel_output_enable_o = channel_output_enable_q;
   assign ack_o = ack_q;
   assign dat_o = dat_q;

endmodule : pwm_output_override_mux

`default_nettype wire

// *** tb/pwm_mux_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwm_mux_checker #(
   parameter int CH_N = pwm_mux_pkg::CH_N
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [pwm_mux_pkg::ADR_W-1:0] adr_i,
   input wire logic [pwm_mux_pkg::DATA_W-1:0] dat_o,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [CH_N-1:0] port_reg_i,
   input wire logic [CH_N-1:0] pin_o,
   input wire logic [CH_N-1:0] pwm_route_o,
   input wire logic [CH_N-1:0] channel_output_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic unmapped;
   assign unmapped = !(adr_i[9:2] inside {8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hc8, 8'hc9});
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   a_ack_after_req: assert property (s_req |=> ack_o)
      else $error("ack missing after request");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_port_path: assert property (!$past(rst_i) |-> ((pin_o ^ $past(port_reg_i)) & ~pwm_route_o) == '0)
      else $error("pin not from port register");
   a_route_needs_enable: assert property (!$past(rst_i) |-> (pwm_route_o & ~$past(channel_output_enable_o)) == '0)
      else $error("route without channel enable");
   a_reset_clears: assert property ($past(rst_i) |-> pwm_route_o == '0 && channel_output_enable_o == '0)
      else $error("route not cleared by reset");
   a_unmapped_zero: assert property (ack_o && $past(unmapped && !we_i) |-> dat_o == '0)
      else $error("unmapped read not zero");
   a_read_data_hold: assert property (!$past(rst_i) && !(ack_o && !$past(we_i)) |-> $stable(dat_o))
      else $error("read data changed without read");
   a_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == '0)
      else $error("read data upper bits not zero");
endmodule : pwm_mux_checker
bind pwm_output_override_mux pwm_mux_checker #(.CH_N(CH_N)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .dat_o(dat_o), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .port_reg_i(port_reg_i), .pin_o(pin_o), .pwm_route_o(pwm_route_o),
   .channel_output_enable_o(channel_output_enable_o));
`default_nettype wire

// *** tb/pin_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [7:0] val_i,
   output logic [7:0] port_reg_o
);
   logic [7:0] port_reg_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) port_reg_q <= 8'h00;
      else if (load_i) port_reg_q <= val_i;
   end
   assign port_reg_o = port_reg_q;
endmodule : pin_side_model
`default_nettype wire

// *** tb/test_pwm_output_override_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pwm_output_override_mux;
   logic clk_i, rst_i, we, cyc, stb, ack, ld;
   logic [9:0] adr;
   logic [31:0] dw, dr;
   logic [3:0] sel;
   logic [7:0] gen, port, pin, route, chen_o, pv, m, d, ps, ce, g, p, rv;
   logic [1:0] o;
   logic [15:0] e;
   logic [3:0] wsel = 4'h1;
   logic [7:0] regs [6] = '{8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hc8, 8'hc9};
   int err_total = 0;
   int num_checks = 0;
   pwm_output_override_mux u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dw), .dat_o(dr),
      .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .pwm_gen_i(gen), .port_reg_i(port),
      .pin_o(pin), .pwm_route_o(route), .channel_output_enable_o(chen_o));
   pin_side_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .load_i(ld), .val_i(pv), .port_reg_o(port));
   always #5 clk_i = ~clk_i;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      num_checks++;
      if (got !== ex) begin
         $display("mismatch %s expected %h seen %h", nm, ex, got);
         err_total++;
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dw <= {24'h0000_00, wd}; sel <= wsel;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = dr[7:0];
      cyc <= 1'b0; stb <= 1'b0;
      if (n >= 50) begin
         $display("mismatch ack expected 1 seen %b", ack);
         err_total++;
         summarize();
      end
   endtask : bus
   function automatic logic [15:0] exp_out(input logic [7:0] m, d, ps, ce, g, p, input logic [1:0] o);
      logic [7:0] r, v;
      for (int n = 0; n < 8; n++) begin
         r[n] = o[n % 2] & ce[n] & ~ps[n];
         v[n] = r[n] ? (m[n] ? d[n] : g[n]) : p[n];
      end
      return {r, v};
   endfunction : exp_out
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_i = 0; rst_i = 1; we = 0; cyc = 0; stb = 0; ld = 0; adr = '0; dw = '0; sel = '0; gen = '0; pv = '0;
      void'($urandom(48));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (regs[k]) begin
         bus(1'b0, regs[k], 8'h00, rv);
         chk("reset value", 8'h00, rv);
      end
      bus(1'b1, 8'h00, 8'hff, rv);
      bus(1'b0, 8'h00, 8'h00, rv);
      chk("unmapped", 8'h00, rv);
      for (int i = 0; i < 40; i++) begin
         {m, d, ps, ce} = $urandom;
         {g, p} = 16'($urandom);
         o = 2'($urandom);
         if (i < 2) begin
            ps = 8'h00; ce = 8'hff; o = 2'h3; m = i ? 8'hff : 8'h00;
         end
         @(posedge clk_i);
         gen <= g; pv <= p; ld <= 1'b1;
         @(posedge clk_i);
         ld <= 1'b0;
         bus(1'b1, 8'hbb, m, rv);
         bus(1'b1, 8'hbc, d, rv);
         bus(1'b1, 8'hbd, ps, rv);
         bus(1'b1, 8'hbe, ce, rv);
         bus(1'b1, 8'hc8, {6'h00, o}, rv);
         bus(1'b0, 8'hbd, 8'h00, rv);
         chk("select readback", ps, rv);
         repeat (2) @(posedge clk_i);
         e = exp_out(m, d, ps, ce, g, p, o);
         chk("pin", e[7:0], pin);
         chk("route", e[15:8], route);
         chk("channel enable", ce, chen_o);
         bus(1'b0, 8'hc9, 8'h00, rv);
         chk("pin readback", e[7:0], rv);
      end
      // Write without lane 0 select is acknowledged but ignored
      wsel = 4'h0;
      bus(1'b1, 8'hbd, ~ps, rv);
      wsel = 4'h1;
      bus(1'b0, 8'hbd, 8'h00, rv);
      chk("masked write", ps, rv);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, 8'hbd, 8'h00, rv);
      chk("select after reset", 8'h00, rv);
      chk("route after reset", 8'h00, route);
      summarize();
   end
endmodule : test_pwm_output_override_mux
`default_nettype wire
